// File: scbs_pkg.sv
// package: shared constants and types for the serial configuration bitstream source
package scbs_pkg;
    // stored image size in bits and address width
    localparam int unsigned IMAGE_BITS = 64;
    localparam int unsigned ADDR_W = 6;
    localparam logic [ADDR_W-1:0] ADDR_START = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 6'h3F;
    // system clock rate and power-on delay
    localparam int unsigned SYS_CLK_HZ = 25000000;
    localparam int unsigned POR_DELAY_MS = 200;
    localparam longint unsigned POR_CYCLES_L = (longint'(POR_DELAY_MS) * SYS_CLK_HZ) / 1000;
    localparam int unsigned POR_CYCLES = int'(POR_CYCLES_L);
    // least output-enable low time in ns and the derived cycle count (rounded up)
    localparam int unsigned OE_LOW_NS = 100;
    localparam int unsigned SYS_CLK_NS = 1000000000 / SYS_CLK_HZ;
    localparam int unsigned OE_LOW_CYCLES = (OE_LOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    // shift clock divider: half period in system cycles
    localparam int unsigned SHIFT_HALF_CYCLES = 4;
    localparam int unsigned CNT_W = 32;
    // host sequencer states
    typedef enum logic [1:0] {SCBS_IDLE, SCBS_RESET, SCBS_SHIFT, SCBS_DONE} scbs_state_t;
endpackage : scbs_pkg

// File: scbs_link_if.sv
// interface: pins between the configuration memory and the target logic device
`timescale 1ns/1ps
interface scbs_link_if;
    // shift clock driven by the target
    logic shiftClockIn;
    // open-drain output-enable: each side drives low when its enable is low
    logic oeTargetOut;
    logic oeTargetEn_n;
    logic oeMemOut;
    logic oeMemEn_n;
    logic oeLine;
    // chip select and cascade
    logic selectInN;
    logic cascadeOutN;
    // serial data from memory, three-state
    logic serialOut;
    logic serialEn_n;
    logic targetSerialIn;
    // wired-and with pull-up on output-enable; float on data reads as 1
    assign oeLine = (oeTargetEn_n | oeTargetOut) & (oeMemEn_n | oeMemOut);
    assign targetSerialIn = serialEn_n ? 1'b1 : serialOut;
    modport mem (input shiftClockIn, input oeLine, input selectInN, output cascadeOutN,
        output serialOut, output serialEn_n, output oeMemOut, output oeMemEn_n);
    modport target (output shiftClockIn, input oeLine, output oeTargetOut,
        output oeTargetEn_n, output selectInN, input targetSerialIn, input cascadeOutN);
endinterface : scbs_link_if

// File: scbs_memory.sv
// module: configuration memory end that streams its stored image on the shift clock
//
// Overview of operation
// - wait power-on delay once, not on reconfiguration
// - target makes and drives the shift clock
// - stored image leaves serially on data output
// - legacy image: target holds enable high, clocks
// - data floats when deselected or finished
// - rising shift clock advances address, next bit
// - count only enabled, selected, not finished
// - low output-enable resets address counter
// - high output-enable drives data, permits counting
// - low select permits counting and drives data
// - cascade output low once clocked past maximum address
// - cascade output feeds next memory's select
// - output-enable held low at least 100 ns
// - chained memories hand off via cascade/select
`timescale 1ns/1ps
module scbs_memory #(
    parameter int unsigned POR_CNT = scbs_pkg::POR_CYCLES,
    parameter logic [scbs_pkg::IMAGE_BITS-1:0] IMAGE = 64'hA5C3_0F1E_5A3C_F0E1
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    // link pins
    scbs_link_if.mem link,
    // status
    output logic ready,
    output logic done
);
    typedef struct packed {
        logic [2:0] clkSync;
        logic oeS1;
        logic oeS2;
        logic selS1;
        logic selS2;
        logic [31:0] porCnt;
        logic porDone;
        logic [scbs_pkg::ADDR_W-1:0] addr;
        logic finished;
        logic dataBit;
    } scbs_mem_state_t;

    scbs_mem_state_t st_r;
    scbs_mem_state_t st_nxt;
    logic clkRise;
    logic counting;

    // edge of the synchronised shift clock
    assign clkRise = st_r.clkSync[1] & ~st_r.clkSync[2];
    assign counting = st_r.porDone & st_r.oeS2 & ~st_r.selS2 & ~st_r.finished;

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.clkSync = {st_r.clkSync[1:0], link.shiftClockIn};
        st_nxt.oeS1 = link.oeLine;
        st_nxt.oeS2 = st_r.oeS1;
        st_nxt.selS1 = link.selectInN;
        st_nxt.selS2 = st_r.selS1;
        // power-on delay only once after reset
        if (!st_r.porDone) begin
            if (st_r.porCnt >= POR_CNT - 1) begin
                st_nxt.porDone = 1'b1;
            end else begin
                st_nxt.porCnt = st_r.porCnt + 32'h1;
            end
        end
        if (!st_r.oeS2) begin
            st_nxt.addr = scbs_pkg::ADDR_START;
            st_nxt.finished = 1'b0;
            st_nxt.dataBit = IMAGE[scbs_pkg::ADDR_START];
        end else if (counting && clkRise) begin
            if (st_r.addr == scbs_pkg::ADDR_LAST) begin
                st_nxt.finished = 1'b1;
            end else begin
                st_nxt.addr = st_r.addr + 1'b1;
                st_nxt.dataBit = IMAGE[st_r.addr + 1'b1];
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    // pin outputs
    assign link.serialOut = st_r.dataBit;
    assign link.serialEn_n = ~(st_r.porDone & st_r.oeS2 & ~st_r.selS2 & ~st_r.finished);
    assign link.cascadeOutN = ~st_r.finished;
    assign link.oeMemOut = 1'b0;
    assign link.oeMemEn_n = st_r.porDone; // hold enable low until ready
    assign ready = st_r.porDone;
    assign done = st_r.finished;
endmodule : scbs_memory

// File: scbs_target.sv
// module: target logic device end that clocks a stored image out of the memory chain
`timescale 1ns/1ps
module scbs_target (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    // link pins
    scbs_link_if.target link,
    // user side
    input wire logic start,
    input wire logic [15:0] bitCount,
    output logic busy,
    output logic bitValid,
    output logic bitData
);
    typedef struct packed {
        scbs_pkg::scbs_state_t state;
        logic [31:0] cnt;
        logic [15:0] left;
        logic clk;
        logic dS1;
        logic dS2;
        logic valid;
        logic dataBit;
    } scbs_tgt_state_t;

    scbs_tgt_state_t st_r;
    scbs_tgt_state_t st_nxt;

    // sequencer: reset pulse, then shift clock from the divider
    always_comb begin
        st_nxt = st_r;
        st_nxt.dS1 = link.targetSerialIn;
        st_nxt.dS2 = st_r.dS1;
        st_nxt.valid = 1'b0;
        unique case (st_r.state)
            scbs_pkg::SCBS_IDLE: begin
                if (start && bitCount != 16'h0) begin
                    st_nxt.state = scbs_pkg::SCBS_RESET;
                    st_nxt.cnt = '0;
                    st_nxt.left = bitCount;
                end
            end
            scbs_pkg::SCBS_RESET: begin
                st_nxt.cnt = st_r.cnt + 32'h1;
                // oe released for five cycles so the data driver is on before the first sample
                if (st_r.cnt >= scbs_pkg::OE_LOW_CYCLES + 8) begin
                    st_nxt.state = scbs_pkg::SCBS_SHIFT;
                    st_nxt.cnt = '0;
                end
            end
            scbs_pkg::SCBS_SHIFT: begin
                st_nxt.cnt = st_r.cnt + 32'h1;
                if (st_r.cnt == scbs_pkg::SHIFT_HALF_CYCLES - 1) begin
                    st_nxt.cnt = '0;
                    st_nxt.clk = ~st_r.clk;
                    if (!st_r.clk) begin
                        st_nxt.valid = 1'b1; // sample just before rising edge
                        st_nxt.dataBit = st_r.dS2;
                        st_nxt.left = st_r.left - 16'h1;
                    end else if (st_r.left == 16'h0) begin
                        // last high phase kept full length before stopping
                        st_nxt.state = scbs_pkg::SCBS_DONE;
                    end
                end
            end
            scbs_pkg::SCBS_DONE: begin
                st_nxt.clk = 1'b0;
                st_nxt.state = scbs_pkg::SCBS_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    // pin and user outputs
    assign link.shiftClockIn = st_r.clk;
    assign link.oeTargetOut = 1'b0;
    assign link.oeTargetEn_n = ~((st_r.state == scbs_pkg::SCBS_RESET)
        && (st_r.cnt < scbs_pkg::OE_LOW_CYCLES + 4));
    assign link.selectInN = 1'b0;
    assign busy = (st_r.state != scbs_pkg::SCBS_IDLE);
    assign bitValid = st_r.valid;
    assign bitData = st_r.dataBit;
endmodule : scbs_target

// File: scbs_link_monitor.sv
// checker: assertions on the link between memory and target
`timescale 1ns/1ps
module scbs_link_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // link signals
    input wire logic shiftClockIn,
    input wire logic oeLine,
    input wire logic oeTargetEn_n,
    input wire logic oeMemEn_n,
    input wire logic cascadeOutN,
    input wire logic serialOut,
    input wire logic serialEn_n
);
    // single clock domain
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // shift clock stays high four cycles, then falls
    sequence s_highPhase;
        shiftClockIn [*4] ##1 !shiftClockIn;
    endsequence
    a_por_oe_hold: assert property ($fell(reset) |-> !oeMemEn_n [*8])
        else $error("oe released early");
    a_clk_half_period: assert property ($rose(shiftClockIn) |-> s_highPhase)
        else $error("bad shift clock");
    a_oe_gates_data: assert property (!oeLine [*4] |-> serialEn_n)
        else $error("data driven with oe low");
    a_data_on_edge: assert property ($changed(serialOut) && !serialEn_n
        && !$past(serialEn_n) && oeLine && $past(oeLine, 6)
        |-> $past(shiftClockIn, 3) && !$past(shiftClockIn, 5))
        else $error("data moved off edge");
    a_cascade_holds: assert property (!cascadeOutN && oeLine |=> !cascadeOutN)
        else $error("cascade released");
    a_cascade_last_bit: assert property ($fell(cascadeOutN) |-> !$past(serialEn_n))
        else $error("last bit not driven");
    a_float_when_done: assert property (!cascadeOutN && oeLine && $rose(shiftClockIn)
        |-> ##[1:5] serialEn_n)
        else $error("data driven after end");
    a_oe_low_width: assert property ($fell(oeTargetEn_n) |-> !oeTargetEn_n [*3])
        else $error("oe low pulse short");
endmodule : scbs_link_monitor

// File: scbs_tb.sv
// testbench: memory and target joined over the link
`timescale 1ns/1ps
module scbs_tb;
    localparam logic [63:0] IMG = 64'h1234_5678_9ABC_DEF0;
    // stream seen by the target, floating line reads as one
    localparam logic [64:0] EXP = {1'b1, IMG};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [15:0] bitCount = 16'h0000;
    logic busy;
    logic bitValid;
    logic bitData;
    logic ready;
    logic done;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    scbs_link_if lnk();
    scbs_memory #(.POR_CNT(10), .IMAGE(IMG)) u_scbs_memory (.sys_clk(sys_clk),
        .reset(reset), .clkEn(1'b1), .link(lnk), .ready(ready), .done(done));
    scbs_target u_scbs_target (.sys_clk(sys_clk), .reset(reset), .clkEn(1'b1), .link(lnk),
        .start(start), .bitCount(bitCount), .busy(busy), .bitValid(bitValid),
        .bitData(bitData));
    scbs_link_monitor u_scbs_link_monitor (.sys_clk(sys_clk), .reset(reset),
        .shiftClockIn(lnk.shiftClockIn), .oeLine(lnk.oeLine),
        .oeTargetEn_n(lnk.oeTargetEn_n), .oeMemEn_n(lnk.oeMemEn_n),
        .cascadeOutN(lnk.cascadeOutN), .serialOut(lnk.serialOut),
        .serialEn_n(lnk.serialEn_n));
    // system clock
    always #20 sys_clk = ~sys_clk;
    // compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // verdict and stop
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // hang limit
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            end_sim();
        end
    end
    // clock n bits out and compare each one in order
    task automatic run_frame(input int n);
        int k;
        int w;
        @(posedge sys_clk);
        start <= 1'b1;
        bitCount <= 16'(n);
        @(posedge sys_clk);
        start <= 1'b0;
        for (k = 0; k < n; k++) begin
            w = 0;
            while (bitValid !== 1'b1 && w < 40) begin
                @(negedge sys_clk);
                w++;
            end
            check(64'(bitData), 64'(EXP[k]));
            @(negedge sys_clk);
        end
        w = 0;
        while (busy !== 1'b0 && w < 40) begin
            @(negedge sys_clk);
            w++;
        end
    endtask : run_frame
    // main sequence: power-on, full image with float, restart
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        check(64'(ready), 64'h0);
        repeat (12) @(negedge sys_clk);
        check(64'(ready), 64'h1);
        run_frame(65);
        check(64'({done, lnk.cascadeOutN}), 64'h2);
        run_frame(4);
        check(64'({done, lnk.cascadeOutN}), 64'h1);
        check(64'(ready), 64'h1);
        end_sim();
    end
endmodule : scbs_tb
